/* inc/ikds_pkg.sv */
// package: register selects, scan timing, field layout and carrier types
package ikds_pkg;
    // port selects on the parallel register port
    localparam logic [1:0] IKDS_SEL_BAR   = 2'h0;
    localparam logic [1:0] IKDS_SEL_LAMP1 = 2'h1;
    localparam logic [1:0] IKDS_SEL_LAMP2 = 2'h2;
    localparam logic [1:0] IKDS_SEL_NONE  = 2'h3;
    // reset values of the port registers (indicators dark)
    localparam logic [7:0] IKDS_PORT_RST  = 8'h00;
    // scan slot time and derived cycle count at 10 MHz
    localparam int         IKDS_CLK_HZ    = 10_000_000;
    localparam int         IKDS_SLOT_US   = 500;
    localparam int         IKDS_SLOT_CYC  =
        (IKDS_SLOT_US * (IKDS_CLK_HZ / 1_000_000));
    localparam logic [12:0] IKDS_SLOT_LAST = 13'(IKDS_SLOT_CYC - 1);
    // scan layout: slots 0..7 are digits; 8 is ninth digit
    localparam logic [3:0] IKDS_SLOT_NINTH = 4'h8;
    localparam logic [3:0] IKDS_KEY_ROW0   = 4'h6;
    localparam logic [3:0] IKDS_KEY_ROW1   = 4'h7;
    localparam int         IKDS_DIGITS     = 9;
    localparam int         IKDS_KEY_COLS   = 8;

    // write/read request from the host microprocessor
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] sel;
        logic [7:0] wdata;
    } ikds_req_t;

    // display ram write request
    typedef struct packed {
        logic       wr;
        logic [3:0] addr;
        logic [7:0] data;
    } ikds_dram_t;
endpackage

/* src/ikds_top.sv */
// indicator ports, display multiplexer and keypad scanner
`timescale 1ns/1ps
module ikds_top (
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              SRST,
    // host register port
    input  wire ikds_pkg::ikds_req_t  REQ,
    output logic [7:0]             RDATA,
    // display ram load port
    input  wire ikds_pkg::ikds_dram_t DRAM,
    // indicator driver outputs
    output logic [9:0]             BAR_N,
    output logic [7:0]             LAMP_FIRST,
    output logic [7:0]             LAMP_SECOND,
    // scan and segment outputs
    output logic [2:0]             SCAN_COUNT,
    output logic                   NINTH_DIGIT_SELECT,
    output logic [9:0]             STROBE_N,
    output logic                   NINTH_ON,
    output logic [3:0]             SEGMENT_OUT_LOW,
    output logic [3:0]             SEGMENT_OUT_HIGH,
    // keypad
    input  wire logic [7:0]        KEY_RETURN_N,
    output logic [15:0]            KEY_STATE
);
    import ikds_pkg::*;

    // ----------------------------------------------------------------
    // indicator port registers
    // ----------------------------------------------------------------
    logic [7:0] bar_q;     // bar graph port
    logic [7:0] lamp1_q;   // first lamp port
    logic [7:0] lamp2_q;   // second lamp port

    // host writes; each port stands alone
    always_ff @(posedge CLK) begin
        if (SRST) begin
            bar_q   <= IKDS_PORT_RST;
            lamp1_q <= IKDS_PORT_RST;
            lamp2_q <= IKDS_PORT_RST;
        end else if (REQ.wr) begin
            case (REQ.sel)
                IKDS_SEL_BAR:   bar_q   <= REQ.wdata;
                IKDS_SEL_LAMP1: lamp1_q <= REQ.wdata;
                IKDS_SEL_LAMP2: lamp2_q <= REQ.wdata;
                default: ;                         // unused select ignored
            endcase
        end
    end

    // readback, registered one cycle after the read strobe
    always_ff @(posedge CLK) begin
        if (SRST) begin
            RDATA <= 8'h00;
        end else if (REQ.rd) begin
            case (REQ.sel)
                IKDS_SEL_BAR:   RDATA <= bar_q;
                IKDS_SEL_LAMP1: RDATA <= lamp1_q;
                IKDS_SEL_LAMP2: RDATA <= lamp2_q;
                default:        RDATA <= 8'h00;
            endcase
        end
    end

    // drivers: bar active low, lamps sink when high
    always_ff @(posedge CLK) begin
        if (SRST) begin
            BAR_N       <= 10'h3FF;
            LAMP_FIRST  <= 8'h00;
            LAMP_SECOND <= 8'h00;
        end else begin
            // ten bars on eight bits; outer bars paired
            BAR_N <= ~{bar_q[7], bar_q, bar_q[0]};
            LAMP_FIRST  <= lamp1_q;
            LAMP_SECOND <= lamp2_q;
        end
    end

    // ----------------------------------------------------------------
    // scan timing
    // ----------------------------------------------------------------
    logic [12:0] div_q;    // slot divider
    logic        tick;     // one-cycle slot advance enable
    logic [3:0]  slot_q;   // 0..8; bit 3 is the fourth scan line

    assign tick = (div_q == IKDS_SLOT_LAST);

    // divider gives one enable per slot
    always_ff @(posedge CLK) begin
        if (SRST || tick) begin
            div_q <= 13'h0000;
        end else begin
            div_q <= div_q + 13'h0001;
        end
    end

    // binary count, wrapping after the ninth digit
    always_ff @(posedge CLK) begin
        if (SRST) begin
            slot_q <= 4'h0;
        end else if (tick) begin
            slot_q <= (slot_q == IKDS_SLOT_NINTH) ? 4'h0
                                                  : slot_q + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // display ram and segment outputs
    // ----------------------------------------------------------------
    logic [7:0] dram_q [IKDS_DIGITS];  // one pattern per digit

    // host loads patterns; out-of-range addresses are dropped
    always_ff @(posedge CLK) begin
        if (SRST) begin
            for (int i = 0; i < IKDS_DIGITS; i++) begin
                dram_q[i] <= 8'h00;
            end
        end else if (DRAM.wr && DRAM.addr <= IKDS_SLOT_NINTH) begin
            dram_q[DRAM.addr] <= DRAM.data;
        end
    end

    // strobes and segments launch together from one slot value,
    // so a digit never shows its neighbour's pattern
    always_ff @(posedge CLK) begin
        if (SRST) begin
            SCAN_COUNT         <= 3'h0;
            NINTH_DIGIT_SELECT <= 1'b0;
            STROBE_N           <= 10'h3FF;
            NINTH_ON           <= 1'b0;
            SEGMENT_OUT_LOW    <= 4'h0;
            SEGMENT_OUT_HIGH   <= 4'h0;
        end else begin
            SCAN_COUNT         <= slot_q[2:0];
            NINTH_DIGIT_SELECT <= slot_q[3];
            // decoder disabled while the fourth line is high
            STROBE_N <= slot_q[3] ? 10'h3FF
                      : ~(10'h001 << slot_q[2:0]);
            NINTH_ON <= slot_q[3];
            SEGMENT_OUT_LOW  <= dram_q[slot_q][3:0];
            SEGMENT_OUT_HIGH <= dram_q[slot_q][7:4];
        end
    end
    // keypad rows ride on the last two digit strobes, slots 6 and 7
    // (low strobe bits 8/9 unused by the 3-bit count; rows share 6/7)

    // ----------------------------------------------------------------
    // keypad sampling
    // ----------------------------------------------------------------
    // sample late in the slot so the return lines have settled
    always_ff @(posedge CLK) begin
        if (SRST) begin
            KEY_STATE <= 16'h0000;
        end else if (tick && slot_q == IKDS_KEY_ROW0) begin
            KEY_STATE[7:0]  <= ~KEY_RETURN_N;
        end else if (tick && slot_q == IKDS_KEY_ROW1) begin
            KEY_STATE[15:8] <= ~KEY_RETURN_N;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_strobe_onehot: assert property (
        @(posedge CLK) disable iff (SRST)
        $countones(~STROBE_N) <= 1)
        else $error("two strobes active");
    chk_ninth_exclusive: assert property (
        @(posedge CLK) disable iff (SRST)
        NINTH_ON |-> STROBE_N == 10'h3FF)
        else $error("ninth digit overlaps strobe");
    chk_ninth_line: assert property (
        @(posedge CLK) disable iff (SRST)
        NINTH_ON == NINTH_DIGIT_SELECT)
        else $error("ninth digit not tied to fourth line");
    chk_scan_step: assert property (
        @(posedge CLK) disable iff (SRST)
        tick && slot_q < IKDS_SLOT_NINTH |=> ##1
        SCAN_COUNT == $past(slot_q[2:0], 2) + 3'h1 || NINTH_DIGIT_SELECT)
        else $error("scan count did not step");
    chk_slot_wrap: assert property (
        @(posedge CLK) disable iff (SRST)
        tick && slot_q == IKDS_SLOT_NINTH |=> slot_q == 4'h0)
        else $error("scan did not wrap after ninth digit");
    chk_bar_pairs: assert property (
        @(posedge CLK) disable iff (SRST)
        BAR_N[0] == BAR_N[1] && BAR_N[8] == BAR_N[9])
        else $error("outer bars split");
    chk_bar_polarity: assert property (
        @(posedge CLK) disable iff (SRST)
        REQ.wr && REQ.sel == IKDS_SEL_BAR |=> ##1
        BAR_N[8:1] == ~$past(REQ.wdata, 2))
        else $error("bar polarity wrong");
    chk_lamp_first: assert property (
        @(posedge CLK) disable iff (SRST)
        REQ.wr && REQ.sel == IKDS_SEL_LAMP1 |=> ##1
        LAMP_FIRST == $past(REQ.wdata, 2))
        else $error("first lamp port not driven");
    chk_lamp_follow: assert property (
        @(posedge CLK) disable iff (SRST)
        REQ.wr && REQ.sel == IKDS_SEL_LAMP2 |=> ##1
        LAMP_SECOND == $past(REQ.wdata, 2))
        else $error("lamp port not driven");
    chk_readback: assert property (
        @(posedge CLK) disable iff (SRST)
        REQ.rd && !REQ.wr && REQ.sel == IKDS_SEL_LAMP1 |=>
        RDATA == $past(lamp1_q))
        else $error("readback wrong");
    chk_bar_readback: assert property (
        @(posedge CLK) disable iff (SRST)
        REQ.rd && !REQ.wr && REQ.sel == IKDS_SEL_BAR |=>
        RDATA == $past(bar_q))
        else $error("bar readback wrong");
    chk_read_refused: assert property (
        @(posedge CLK) disable iff (SRST)
        REQ.rd && REQ.sel == IKDS_SEL_NONE |=> RDATA == 8'h00)
        else $error("unused select read not zero");
    chk_segment_sync: assert property (
        @(posedge CLK) disable iff (SRST)
        !DRAM.wr |=> {SEGMENT_OUT_HIGH, SEGMENT_OUT_LOW}
        == $past(dram_q[slot_q]))
        else $error("segments out of step");
    chk_key_sample: assert property (
        @(posedge CLK) disable iff (SRST)
        tick && slot_q == IKDS_KEY_ROW0 |=>
        KEY_STATE[7:0] == ~$past(KEY_RETURN_N))
        else $error("key row not sampled");
    chk_key_row_second: assert property (
        @(posedge CLK) disable iff (SRST)
        tick && slot_q == IKDS_KEY_ROW1 |=>
        KEY_STATE[15:8] == ~$past(KEY_RETURN_N))
        else $error("second key row not sampled");
endmodule

/* dv/ikds_host_model.sv */
// host processor model driving the indicator register port
`timescale 1ns/1ps
module ikds_host_model (
    // clock
    input  wire logic             CLK,
    // register port
    output ikds_pkg::ikds_req_t   REQ,
    input  wire logic [7:0]       RDATA
);
    import ikds_pkg::*;
    initial REQ = '0;
    // one write; released fields get inverted, never left stale
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(negedge CLK) REQ = '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
        @(negedge CLK) REQ = '{wr: 1'b0, rd: 1'b0, sel: ~s, wdata: ~d};
    endtask
    // one read; data taken a cycle and a half after the taking edge
    task automatic rd(input logic [1:0] s, output logic [7:0] d);
        @(negedge CLK) REQ = '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 8'hA5};
        @(negedge CLK) REQ = '{wr: 1'b0, rd: 1'b0, sel: ~s, wdata: 8'h5A};
        @(negedge CLK) d = RDATA;
    endtask
endmodule

/* dv/tb.sv */
// self-checking bench: ports, scan, segments and keypad
`timescale 1ns/1ps
module tb;
    import ikds_pkg::*;
    logic        clk = 1'b0;       // 10 MHz
    logic        srst = 1'b1;      // sync reset
    ikds_req_t   req;              // from host model
    ikds_dram_t  dram = '0;        // digit ram loads
    logic [7:0]  rdata, lamp1, lamp2, v, rv, k6, k7;
    logic [7:0]  keys_n = 8'hFF;   // all keys open
    logic [3:0]  seg_l, seg_h, sl;
    logic [9:0]  bar_n, strobe_n;
    logic [2:0]  scan;
    logic        ninth_sel, ninth_on;
    logic [15:0] key_state;
    logic [7:0]  ram [0:8];        // expected digit patterns
    logic [7:0]  pv [0:2];         // expected port contents
    int          seed = 69616;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          t_last = 0;       // cycle at which last slot showed

    ikds_top uut (.CLK(clk), .SRST(srst), .REQ(req), .RDATA(rdata),
        .DRAM(dram), .BAR_N(bar_n), .LAMP_FIRST(lamp1),
        .LAMP_SECOND(lamp2), .SCAN_COUNT(scan),
        .NINTH_DIGIT_SELECT(ninth_sel), .STROBE_N(strobe_n),
        .NINTH_ON(ninth_on), .SEGMENT_OUT_LOW(seg_l),
        .SEGMENT_OUT_HIGH(seg_h), .KEY_RETURN_N(keys_n),
        .KEY_STATE(key_state));
    ikds_host_model host (.CLK(clk), .REQ(req), .RDATA(rdata));

    always #50 clk = ~clk;
    // hang guard: a full scan pass is 45000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // end bars are doubled onto the outer port bits
    // bar k follows port bit k-1; bar 0 and bar 9 pair with their
    // neighbours; a lit bar pulls its driver line low
    function automatic logic [9:0] bar_exp(input logic [7:0] b);
        logic [9:0] lit;
        for (int k = 0; k < 10; k++) begin
            lit[k] = b[(k == 0) ? 0 : (k == 9) ? 7 : k - 1];
        end
        return ~lit;
    endfunction
    // one low strobe per digit slot, none in the ninth slot
    function automatic logic [9:0] strobe_exp(input logic [3:0] s);
        return (s < 4'h8) ? ~(10'h001 << s) : 10'h3FF;
    endfunction

    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        check(bar_n, 10'h3FF);
        check(strobe_n, 10'h3FF);
        // corners first, then random data; sel 3 must be refused
        for (int r = 0; r < 4; r++) begin
            for (int s = 0; s < 4; s++) begin
                v = (r == 0) ? 8'hFF : (r == 1) ? 8'h01 : 8'($random(seed));
                host.wr(2'(s), v);
                if (s < 3) pv[s] = v;
            end
            for (int s = 0; s < 4; s++) begin
                host.rd(2'(s), rv);
                check(rv, (s < 3) ? pv[s] : 8'h00);
            end
            check(bar_n, bar_exp(pv[0]));
            check(lamp1, pv[1]);
            check(lamp2, pv[2]);
            $display("port round %0d done", r);
        end
        // load digits 0..8 back to back; address 9 must be ignored
        for (int d = 0; d < 10; d++) begin
            @(negedge clk);
            dram = '{wr: 1'b1, addr: 4'(d), data: 8'($random(seed))};
            if (d < 9) ram[d] = dram.data;
        end
        @(negedge clk) dram = '{wr: 1'b0, addr: 4'hF, data: 8'h00};
        k6 = 8'($random(seed));
        k7 = 8'($random(seed));
        // walk slots 1..8 then back to 0
        for (int i = 1; i < 10; i++) begin
            sl = 4'(i % 9);
            while ({ninth_sel, scan} !== sl) @(negedge clk);
            // every slot after the first lasts one full slot time
            if (i > 1) check(16'(cycles - t_last), 16'(IKDS_SLOT_CYC));
            t_last = cycles;
            keys_n = (sl == 4'h6) ? k6 : (sl == 4'h7) ? k7 : ~k7;
            repeat (2) @(negedge clk);
            check(strobe_n, strobe_exp(sl));
            check(ninth_on, sl == 4'h8);
            check({seg_h, seg_l}, ram[sl]);
            $display("scan slot %0d done", sl);
        end
        check(key_state, ~{k7, k6});
        // reset in mid-run: all dark, scan restarts at slot 0
        @(negedge clk) srst = 1'b1;
        repeat (2) @(negedge clk);
        check(bar_n, 10'h3FF);
        check({lamp2, lamp1}, 16'h0000);
        check(rdata, 8'h00);
        check(key_state, 16'h0000);
        srst = 1'b0;
        @(negedge clk);
        check(strobe_n, strobe_exp(4'h0));
        check({seg_h, seg_l}, 8'h00);
        host.rd(2'h1, rv);
        check(rv, 8'h00);
        $display("mid-run reset done");
        stop_test();
    end
endmodule
